// File: rtl/mft_timer_ctrl.sv
// What this block does
// - count only when local and global enables
// - capture and load work while disabled
// - capture clears counter, reloads prescaler when enabled
// - match zero clears counter when enabled
// - clear strobe clears counter, reads zero
// - software direction bit when pins silent
// - direction status bit shows count direction
// - status shows wrap during slot-zero capture
// - run status bit shows counter running
// - output gate off forces output high
// - mode from bivalue and slot bits
// - slot-one bit ignored in bivalue mode
// - parallel bit blocks prescaler ticks, odd instances only
// - retrigger bit zero enables retrigger
// - one-shot bit stops at end count
// - function code assigns both pin roles
// - pin one edge select encoding
// - pin two edge select encoding
// - preset loaded at underflow or reload
// - prescaler zero after reset
// - prescaler divides by preset plus one
// - match registers sixteen bits compared
// - capture/load slots capture or supply load
// - wrap flag sticky until software clears
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module mft_timer_ctrl
  import mft_pkg::*;
#(
  parameter bit ODD_INSTANCE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_input_one,
  input wire logic ext_input_two,
  output logic timer_output_one,
  output logic timer_output_two,
  output logic [15:0] count_value
);
  ////////////////////////////////////////////////////////////////////////////
  logic rstMeta, rstSync, rstLocal_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end
  assign rstLocal_n = rstSync;

  logic [1:0] syncOne, syncTwo;
  logic lastOne, lastTwo;
  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      syncOne <= 2'h0;
      syncTwo <= 2'h0;
      lastOne <= 1'b0;
      lastTwo <= 1'b0;
    end else begin
      syncOne <= {syncOne[0], ext_input_one};
      syncTwo <= {syncTwo[0], ext_input_two};
      lastOne <= syncOne[1];
      lastTwo <= syncTwo[1];
    end
  end
  wire pinOne = syncOne[1];
  wire pinTwo = syncTwo[1];

  function automatic logic edgeHit(input logic [1:0] sel, input logic now,
                                   input logic prev);
    case (sel)
      EDGE_FALL: edgeHit = prev & ~now;
      EDGE_RISE: edgeHit = ~prev & now;
      EDGE_BOTH: edgeHit = prev ^ now;
      default: edgeHit = 1'b0;
    endcase
  endfunction : edgeHit

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl, mode, pinCfg, preset, globalCtrl;
  logic [15:0] slotZero, slotOne, matchZero, matchOne;
  logic [15:0] counter;
  logic [7:0] prescaler;
  logic wrapFlag, wrapAtCapture, oneShotDone, outOne, outTwo;

  wire [9:0] regIdx = paddr[11:2];
  wire setupWr = psel & ~penable & pwrite;
  wire accWr = psel & penable & pwrite;
  wire knownIdx = regIdx[9:8] == 2'h0 && regIdx[7:0] >= IDX_CL0_HIGH &&
                  regIdx[7:0] <= IDX_GLOBAL;
  wire wrEn = accWr & knownIdx;
  wire [7:0] wrByte = pwdata[7:0];
  function automatic logic hitW(input logic [7:0] idx, input logic en,
                                input logic [9:0] a);
    hitW = en && a == {2'h0, idx};
  endfunction : hitW
  wire unusedSetup = setupWr;

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  mft_mode_e opMode;
  always_comb begin
    if (mode[OM_BIVAL])
      opMode = mode[OM_SLOT0] ? MD_BICAPTURE : MD_BILOAD;
    else
      case ({mode[OM_SLOT1], mode[OM_SLOT0]})
        2'b00: opMode = MD_LOAD_MON;
        2'b10: opMode = MD_LOAD_CAP;
        2'b01: opMode = MD_CAP_MON;
        default: opMode = MD_CAP_CAP;
      endcase
  end
  wire slot0Cap = opMode == MD_BICAPTURE || opMode == MD_CAP_MON ||
                  opMode == MD_CAP_CAP;
  wire slot1Cap = opMode == MD_BICAPTURE || opMode == MD_LOAD_CAP ||
                  opMode == MD_CAP_CAP;

  // pin roles
  wire [3:0] fn = pinCfg[7:4];
  wire evOne = edgeHit(pinCfg[3:2], pinOne, lastOne);
  wire evTwo = edgeHit(pinCfg[1:0], pinTwo, lastTwo);
  logic trigOne, trigTwo, gateOne, gateTwo, clkTwo, clkOne, udPin;
  always_comb begin
    trigOne = 1'b0;
    trigTwo = 1'b0;
    gateOne = 1'b0;
    gateTwo = 1'b0;
    clkOne = 1'b0;
    clkTwo = 1'b0;
    udPin = 1'b0;
    case (fn)
      4'h1: trigTwo = 1'b1;
      4'h2: gateOne = 1'b1;
      4'h3: begin gateOne = 1'b1; trigTwo = 1'b1; end
      4'h4: clkTwo = 1'b1;
      4'h5: trigOne = 1'b1;
      4'h6: begin gateOne = 1'b1; clkTwo = 1'b1; end
      4'h7: begin trigOne = 1'b1; trigTwo = 1'b1; end
      4'h9: begin udPin = 1'b1; clkTwo = 1'b1; end
      4'ha: begin trigOne = 1'b1; trigTwo = 1'b1; end
      4'hb: udPin = 1'b1;
      4'hd: begin trigOne = 1'b1; clkTwo = 1'b1; end
      4'he: begin clkOne = 1'b1; trigTwo = 1'b1; end
      4'hf: begin trigOne = 1'b1; gateTwo = 1'b1; end
      default: ;
    endcase
  end
  wire pinsSetDir = fn == FN_CLKUPDN || fn == FN_AUTODISC || fn == 4'ha ||
                    udPin;
  // autodiscrimination: direction from which pin is high at the other edge
  logic pinDir;
  always_comb begin
    case (fn)
      FN_CLKUPDN, 4'ha: pinDir = evOne;
      FN_AUTODISC: pinDir = evOne ? ~pinTwo : pinOne;
      default: pinDir = pinOne;
    endcase
  end
  logic dirLatched;
  wire countUp = pinsSetDir ? dirLatched : ctrl[CC_DIRSEL];

  // clock source: external clock edges or internal prescaler
  wire parMode = mode[OM_PAR] & ODD_INSTANCE;
  wire extClk = fn == FN_CLKUPDN || fn == FN_AUTODISC ? (evOne | evTwo) :
                clkTwo ? evTwo : clkOne ? evOne : 1'b0;
  wire usesExt = fn == FN_CLKUPDN || fn == FN_AUTODISC || clkOne | clkTwo;
  wire gateOk = (~gateOne | pinOne) & (~gateTwo | pinTwo);
  wire enabled = ctrl[CC_EN] & globalCtrl[0] & ~oneShotDone;
  wire running = enabled & gateOk;
  wire preUnder = running & ~usesExt & ~parMode & prescaler == 8'h00;
  wire tick = running & (usesExt ? extClk : preUnder);

  // events
  wire trigAny = (trigOne & evOne) | (trigTwo & evTwo);
  wire cap0 = slot0Cap & trigAny;
  wire cap1 = slot1Cap & (opMode == MD_BICAPTURE ? (trigTwo & evTwo) :
              trigAny);
  wire loadEv = ~slot0Cap & trigAny &
                (~oneShotDone | ~mode[OM_NORETRIG]);
  wire endUp = countUp && counter == 16'hffff;
  wire endDown = ~countUp && counter == 16'h0000;
  wire wrapEv = tick & (endUp | endDown);
  wire match0 = tick && counter == matchZero;
  wire match1 = tick && counter == matchOne;
  wire clrStrobe = hitW(IDX_CTRL, wrEn, regIdx) & wrByte[CC_CLRSTB];
  wire clrCap = ctrl[CC_CLRCAP] & (cap0 | cap1);
  wire clrMatch = ctrl[CC_CLRMATCH] & match0;
  wire clearCnt = clrCap | clrMatch | clrStrobe;
  wire reload = loadEv | (wrapEv & ~mode[OM_ONESHOT]);
  wire [15:0] loadVal = opMode == MD_BILOAD && countUp ? slotOne : slotZero;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      counter <= 16'h0000;
      prescaler <= RST_BYTE;
      dirLatched <= 1'b1;
      oneShotDone <= 1'b0;
      wrapFlag <= 1'b0;
      wrapAtCapture <= 1'b0;
    end else begin
      if (pinsSetDir && (evOne | evTwo))
        dirLatched <= pinDir;
      if (clearCnt)
        counter <= 16'h0000;
      else if (reload)
        counter <= loadVal;
      else if (tick)
        counter <= countUp ? counter + 16'h0001 : counter - 16'h0001;
      // preset enters only at underflow, reload, or a capture or match clear
      if (clrCap | clrMatch | reload | preUnder)
        prescaler <= preset;
      else if (running & ~usesExt)
        prescaler <= prescaler - 8'h01;
      if (wrapEv & mode[OM_ONESHOT])
        oneShotDone <= 1'b1;
      else if (hitW(IDX_CTRL, wrEn, regIdx) | loadEv)
        oneShotDone <= 1'b0;
      // set wins over software clear
      if (wrapEv)
        wrapFlag <= 1'b1;
      else if (hitW(IDX_STATUS, wrEn, regIdx) & wrByte[0])
        wrapFlag <= 1'b0;
      if (cap0)
        wrapAtCapture <= wrapFlag | wrapEv;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      ctrl <= RST_BYTE;
      mode <= RST_BYTE;
      pinCfg <= RST_BYTE;
      preset <= RST_BYTE;
      globalCtrl <= RST_GLOBAL;
      matchZero <= 16'h0000;
      matchOne <= 16'h0000;
    end else begin
      if (hitW(IDX_CTRL, wrEn, regIdx))
        ctrl <= {wrByte[7:5], 1'b0, wrByte[3], 3'h0};
      if (hitW(IDX_MODE, wrEn, regIdx))
        mode <= wrByte;
      if (hitW(IDX_PINCFG, wrEn, regIdx))
        pinCfg <= wrByte;
      if (hitW(IDX_PRESET, wrEn, regIdx))
        preset <= wrByte;
      if (hitW(IDX_GLOBAL, wrEn, regIdx))
        globalCtrl <= {7'h00, wrByte[0]};
      if (hitW(IDX_M0_HIGH, wrEn, regIdx))
        matchZero[15:8] <= wrByte;
      if (hitW(IDX_M0_LOW, wrEn, regIdx))
        matchZero[7:0] <= wrByte;
      if (hitW(IDX_M1_HIGH, wrEn, regIdx))
        matchOne[15:8] <= wrByte;
      if (hitW(IDX_M1_LOW, wrEn, regIdx))
        matchOne[7:0] <= wrByte;
    end
  end

  // capture/load slots: reset value left at zero for determinism
  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      slotZero <= 16'h0000;
      slotOne <= 16'h0000;
    end else begin
      if (cap0)
        slotZero <= counter;
      else if (hitW(IDX_CL0_HIGH, wrEn, regIdx))
        slotZero[15:8] <= wrByte;
      else if (hitW(IDX_CL0_LOW, wrEn, regIdx))
        slotZero[7:0] <= wrByte;
      if (cap1)
        slotOne <= counter;
      else if (hitW(IDX_CL1_HIGH, wrEn, regIdx))
        slotOne[15:8] <= wrByte;
      else if (hitW(IDX_CL1_LOW, wrEn, regIdx))
        slotOne[7:0] <= wrByte;
    end
  end

  // outputs: toggle on match zero / wrap while gated on
  always_ff @(posedge clk_sys or negedge rstLocal_n) begin
    if (!rstLocal_n) begin
      outOne <= 1'b1;
      outTwo <= 1'b1;
    end else begin
      outOne <= ~mode[OM_OUT1] ? 1'b1 : outOne ^ match0;
      outTwo <= ~mode[OM_OUT2] ? 1'b1 : outTwo ^ wrapEv;
    end
  end
  assign timer_output_one = outOne;
  assign timer_output_two = outTwo;
  assign count_value = counter;

  ////////////////////////////////////////////////////////////////////////////
  wire [7:0] ctrlRead = {ctrl[7:5], 1'b0, ctrl[3], countUp, wrapAtCapture,
                         running};
  logic [7:0] rdByte;
  always_comb begin
    case (regIdx[7:0])
      IDX_CL0_HIGH: rdByte = slotZero[15:8];
      IDX_CL0_LOW: rdByte = slotZero[7:0];
      IDX_CL1_HIGH: rdByte = slotOne[15:8];
      IDX_CL1_LOW: rdByte = slotOne[7:0];
      IDX_M0_HIGH: rdByte = matchZero[15:8];
      IDX_M0_LOW: rdByte = matchZero[7:0];
      IDX_M1_HIGH: rdByte = matchOne[15:8];
      IDX_M1_LOW: rdByte = matchOne[7:0];
      IDX_CTRL: rdByte = ctrlRead;
      IDX_MODE: rdByte = mode;
      IDX_PINCFG: rdByte = pinCfg;
      IDX_PRESET: rdByte = preset;
      IDX_STATUS: rdByte = {7'h00, wrapFlag};
      IDX_GLOBAL: rdByte = globalCtrl;
      default: rdByte = 8'h00;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~knownIdx & ~unusedSetup;
  assign prdata = {24'h000000, knownIdx ? rdByte : 8'h00};

  ////////////////////////////////////////////////////////////////////////////
  chk_strobe_reads_zero: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n) ctrl[CC_CLRSTB] == 1'b0)
    else $error("clear strobe stuck");
  chk_strobe_clears: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n) clrStrobe |=> counter == 16'h0000)
    else $error("clear strobe ignored");
  chk_stop_halts: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n)
    !ctrl[CC_EN] && !clearCnt && !reload |=> $stable(counter))
    else $error("counter moved while disabled");
  chk_match_clears: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n) clrMatch |=> counter == 16'h0000)
    else $error("match did not clear");
  chk_wrap_sticky: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n) wrapEv |=> wrapFlag)
    else $error("wrap flag not set");
  chk_gate_high: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n) !mode[OM_OUT1] |=> timer_output_one)
    else $error("gated output not high");
  chk_capture_slot: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n) cap0 && !clearCnt |=>
    slotZero == $past(counter))
    else $error("capture lost");
  chk_preset_load: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n) preUnder |=> prescaler == $past(preset))
    else $error("preset not loaded");
  // clears outrank reload and count, so these hold on any edge
  chk_capture_clears: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n) clrCap |=> counter == 16'h0000)
    else $error("capture did not clear");
  chk_oneshot_stops: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n) wrapEv && mode[OM_ONESHOT] |=> !running)
    else $error("one-shot kept running");
  chk_global_halt: assert property (@(posedge clk_sys)
    disable iff (!rstLocal_n)
    !globalCtrl[0] && !clearCnt && !reload |=> $stable(counter))
    else $error("counter moved while globally off");
endmodule : mft_timer_ctrl

// File: rtl/mft_pkg.sv
package mft_pkg;
  // register byte addresses (printed offsets are not all multiples of four,
  // so they are kept as indices and the bus address is four times the index)
  localparam logic [7:0] IDX_CL0_HIGH = 8'hf0;
  localparam logic [7:0] IDX_CL0_LOW = 8'hf1;
  localparam logic [7:0] IDX_CL1_HIGH = 8'hf2;
  localparam logic [7:0] IDX_CL1_LOW = 8'hf3;
  localparam logic [7:0] IDX_M0_HIGH = 8'hf4;
  localparam logic [7:0] IDX_M0_LOW = 8'hf5;
  localparam logic [7:0] IDX_M1_HIGH = 8'hf6;
  localparam logic [7:0] IDX_M1_LOW = 8'hf7;
  localparam logic [7:0] IDX_CTRL = 8'hf8;
  localparam logic [7:0] IDX_MODE = 8'hf9;
  localparam logic [7:0] IDX_PINCFG = 8'hfa;
  localparam logic [7:0] IDX_PRESET = 8'hfb;
  localparam logic [7:0] IDX_STATUS = 8'hfc;
  localparam logic [7:0] IDX_GLOBAL = 8'hfd;
  // counter_control fields
  localparam int CC_EN = 7;
  localparam int CC_CLRCAP = 6;
  localparam int CC_CLRMATCH = 5;
  localparam int CC_CLRSTB = 4;
  localparam int CC_DIRSEL = 3;
  localparam int CC_DIRST = 2;
  localparam int CC_WRAPCAP = 1;
  localparam int CC_RUN = 0;
  // operating_mode fields
  localparam int OM_OUT2 = 7;
  localparam int OM_OUT1 = 6;
  localparam int OM_BIVAL = 5;
  localparam int OM_SLOT1 = 4;
  localparam int OM_SLOT0 = 3;
  localparam int OM_PAR = 2;
  localparam int OM_NORETRIG = 1;
  localparam int OM_ONESHOT = 0;
  // edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // input function codes
  localparam logic [3:0] FN_UNUSED = 4'h0;
  localparam logic [3:0] FN_CLKUPDN = 4'h8;
  localparam logic [3:0] FN_AUTODISC = 4'hc;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_GLOBAL = 8'h01;
  typedef enum logic [2:0] {
    MD_BILOAD, MD_BICAPTURE, MD_LOAD_MON, MD_LOAD_CAP, MD_CAP_MON, MD_CAP_CAP
  } mft_mode_e;
endpackage : mft_pkg

// File: dv/mft_pin_model.sv
`timescale 1ns/1ps
module mft_pin_model (
  input wire logic clk_sys,
  input wire logic run,
  output logic pinOne,
  output logic pinTwo
);
  int seed;
  initial begin
    seed = 32'h9be8cc54;
    pinOne = 1'b0;
    pinTwo = 1'b0;
  end
  // pins wander only on request; at rest they hold their last value, low before the first request
  always @(posedge clk_sys) begin
    if (run) begin
      pinOne <= 1'($random(seed));
      pinTwo <= 1'($random(seed));
    end
  end
endmodule : mft_pin_model

// File: dv/multifunction_updown_timer_ctrl_tb.sv
`timescale 1ns/1ps
module multifunction_updown_timer_ctrl_tb;
  import mft_pkg::*;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
  logic pinOne, pinTwo, pinRun, outOne, outTwo, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] countValue, c0, peak;
  logic [7:0] pre, v;
  logic [7:0] rwIdx [8];
  int miscompares, checks, seed, lowSeen, highLost;

  mft_timer_ctrl i_mft_timer_ctrl (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_input_one(pinOne), .ext_input_two(pinTwo),
    .timer_output_one(outOne), .timer_output_two(outTwo),
    .count_value(countValue));
  mft_pin_model i_mft_pin_model (.clk_sys(clk_sys), .run(pinRun),
    .pinOne(pinOne), .pinTwo(pinTwo));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask : rdchk

  function automatic logic [15:0] steps(input int n, input logic [7:0] p,
                                        input logic up);
    logic [15:0] k;
    k = 16'(n / (int'(p) + 1));
    return up ? k : 16'(-k);
  endfunction : steps

  // windows are whole prescaler periods, so the count advance is exact
  task automatic span(input int n, input logic [15:0] exp);
    @(posedge clk_sys);
    #1 c0 = countValue;
    repeat (n) @(posedge clk_sys);
    #1 chk({16'h0, 16'(countValue - c0)}, {16'h0, exp});
  endtask : span

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (rst_n) begin
      if (outOne === 1'b0) lowSeen++;
      if (outTwo !== 1'b1) highLost++;
    end
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    seed = 32'h9be8cc54;
    {rst_n, psel, penable, pwrite, pinRun} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rwIdx = '{IDX_CL1_LOW, IDX_M0_HIGH, IDX_M0_LOW, IDX_M1_HIGH,
              IDX_M1_LOW, IDX_MODE, IDX_PINCFG, IDX_PRESET};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    for (int i = 1; i < 8; i++) rdchk(rwIdx[i], RST_BYTE);
    rdchk(IDX_CTRL, RST_BYTE);
    rdchk(IDX_GLOBAL, RST_GLOBAL);
    chk({30'h0, outOne, outTwo}, 32'h3);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed)) & 8'h7f;
      apb(1'b1, rwIdx[i], v);
      rdchk(rwIdx[i], v);
    end
    apb(1'b1, IDX_MODE, 8'h00);
    apb(1'b1, IDX_PINCFG, 8'h00);
    apb(1'b0, 8'h10, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, IDX_CTRL, 8'h10);
    apb(1'b0, IDX_CTRL, 8'h00);
    chk({31'h0, rd[CC_CLRSTB]}, 32'h0);
    $display("test register access done");
    pre = (8'($random(seed)) & 8'h07) | 8'h01;
    apb(1'b1, IDX_PRESET, pre);
    apb(1'b1, IDX_CTRL, 8'h88);
    // climb far enough that the down span cannot reach an underflow
    repeat (16 * (int'(pre) + 1)) @(posedge clk_sys);
    span(4 * (int'(pre) + 1), steps(4 * (int'(pre) + 1), pre, 1'b1));
    apb(1'b0, IDX_CTRL, 8'h00);
    chk(rd & 32'h8d, 32'h8d);
    apb(1'b1, IDX_CTRL, 8'h80);
    span(8 * (int'(pre) + 1), steps(8 * (int'(pre) + 1), pre, 1'b0));
    apb(1'b0, IDX_CTRL, 8'h00);
    chk(rd & 32'h0d, 32'h01);
    apb(1'b1, IDX_GLOBAL, 8'h00);
    span(20, 16'h0);
    apb(1'b1, IDX_GLOBAL, 8'h01);
    apb(1'b1, IDX_CTRL, 8'h00);
    span(20, 16'h0);
    apb(1'b0, IDX_CTRL, 8'h00);
    chk({31'h0, rd[CC_RUN]}, 32'h0);
    apb(1'b1, IDX_CTRL, 8'h10);
    repeat (3) @(posedge clk_sys);
    #1 chk({16'h0, countValue}, 32'h0);
    $display("test counting done");
    apb(1'b1, IDX_STATUS, 8'h01);
    apb(1'b1, IDX_MODE, 8'h01);
    apb(1'b1, IDX_CTRL, 8'h80);
    repeat (20) @(posedge clk_sys);
    apb(1'b0, IDX_CTRL, 8'h00);
    chk(rd & 32'h81, 32'h80);
    apb(1'b1, IDX_CTRL, 8'h00);
    repeat (10) @(posedge clk_sys);
    rdchk(IDX_STATUS, 8'h01);
    apb(1'b1, IDX_STATUS, 8'h01);
    rdchk(IDX_STATUS, 8'h00);
    $display("test wrap flag done");
    apb(1'b1, IDX_PRESET, 8'h00);
    apb(1'b1, IDX_M0_HIGH, 8'h00);
    apb(1'b1, IDX_M0_LOW, 8'h05);
    apb(1'b1, IDX_MODE, 8'h40);
    apb(1'b1, IDX_CTRL, 8'h10);
    lowSeen = 0;
    peak = 16'h0;
    apb(1'b1, IDX_CTRL, 8'ha8);
    repeat (60) begin
      @(posedge clk_sys);
      #1 if (countValue > peak) peak = countValue;
    end
    chk({16'h0, peak}, 32'h5);
    chk({31'h0, lowSeen > 0}, 32'h1);
    apb(1'b1, IDX_CTRL, 8'h40);
    apb(1'b1, IDX_MODE, 8'h08);
    $display("test match clear done");
    pinRun <= 1'b1;
    for (int f = 0; f < 16; f++) begin
      for (int e = 0; e < 4; e++) begin
        v = {4'(f), 2'(e), 2'(3 - e)};
        apb(1'b1, IDX_PINCFG, v);
        rdchk(IDX_PINCFG, v);
      end
    end
    pinRun <= 1'b0;
    apb(1'b1, IDX_PINCFG, 8'h00);
    #1 chk({16'h0, countValue}, 32'h0);
    chk(32'(highLost), 32'h0);
    $display("test pin config done");
    tally_and_finish();
  end
endmodule : multifunction_updown_timer_ctrl_tb
